// file: dct_checker.sv
`default_nettype none
// port checker for the timer pair
module dct_checker (
    // clock and reset
    input wire logic       clk,
    input wire logic       rst,
    // register port
    input wire logic [3:0] regAddr,
    input wire logic       regWrEn,
    input wire logic [7:0] regWrData,
    input wire logic [7:0] regRdData_q,
    // pins and interrupts
    input wire logic       measIn,
    input wire logic       shortOut_q,
    input wire logic       wideOut_q,
    input wire logic       shortIrq_q,
    input wire logic       wideIrq_q
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       txMode_q, tieS_q, tieW_q, cieW_q;
    logic [3:0] quiet_q;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // mirror control bits that only software writes
    always @(posedge clk) begin
        if (rst) begin
            {txMode_q, tieS_q, tieW_q, cieW_q} <= 4'h0;
        end else if (regWrEn && regAddr == 4'h1) begin
            txMode_q <= regWrData[7];
        end else if (regWrEn && regAddr == 4'h0) begin
            tieS_q <= regWrData[1];
        end else if (regWrEn && regAddr == 4'h2) begin
            {tieW_q, cieW_q} <= {regWrData[1], regWrData[2]};
        end
    end
    // cycles the measured line has stayed still, saturating
    always @(posedge clk) begin
        if (rst || !$stable(measIn)) begin
            quiet_q <= 4'h0;
        end else if (quiet_q != 4'hF) begin
            quiet_q <= quiet_q + 4'h1;
        end
    end
    property p_reset_quiet;
        disable iff (1'b0) rst |=> !shortOut_q && !wideOut_q && !shortIrq_q && !wideIrq_q;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("outputs not cleared by reset");
    property p_unmapped_zero;
        (regAddr == 4'h3 || regAddr >= 4'hC) |=> regRdData_q == 8'h00;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero)
        else $error("unmapped read not zero");
    property p_capture_write_ignored;
        regAddr == 4'hB ##1 (regAddr == 4'hB && regWrEn && quiet_q == 4'hF)
            ##1 regAddr == 4'hB |=> $stable(regRdData_q);
    endproperty
    a_capture_write_ignored: assert property (p_capture_write_ignored)
        else $error("capture changed by write");
    property p_reload_readback;
        (regWrEn && regAddr >= 4'h4 && regAddr <= 4'h7) ##1 regAddr == $past(regAddr)
            |=> regRdData_q == $past(regWrData, 2);
    endproperty
    a_reload_readback: assert property (p_reload_readback)
        else $error("reload value not held");
    property p_short_irq_masked;
        !$past(tieS_q) |-> !shortIrq_q;
    endproperty
    a_short_irq_masked: assert property (p_short_irq_masked)
        else $error("short interrupt while disabled");
    property p_wide_irq_masked;
        !$past(tieW_q) && !$past(cieW_q) |-> !wideIrq_q;
    endproperty
    a_wide_irq_masked: assert property (p_wide_irq_masked)
        else $error("wide interrupt while disabled");
    property p_short_irq_holds;
        shortIrq_q && !$past(regWrEn && regAddr == 4'h0) |=> shortIrq_q;
    endproperty
    a_short_irq_holds: assert property (p_short_irq_holds)
        else $error("short interrupt dropped");
    property p_wide_irq_holds;
        wideIrq_q && !$past(regWrEn && regAddr == 4'h2) |=> wideIrq_q;
    endproperty
    a_wide_irq_holds: assert property (p_wide_irq_holds)
        else $error("wide interrupt dropped");
    property p_short_irq_at_toggle;
        $rose(shortIrq_q) && $past(tieS_q, 2) && txMode_q
            |-> $past(shortOut_q) != $past(shortOut_q, 2);
    endproperty
    a_short_irq_at_toggle: assert property (p_short_irq_at_toggle)
        else $error("short interrupt without output toggle");
endmodule // dct_checker
`default_nettype wire

// file: dct_consts.vh
`ifndef DCT_CONSTS_VH
`define DCT_CONSTS_VH

// register offsets inside expanded bank D (4-bit working register address)
`define DCT_ADDR_SCTL   4'h0
`define DCT_ADDR_SHCTL  4'h1
`define DCT_ADDR_WCTL   4'h2
`define DCT_ADDR_SRLO   4'h4
`define DCT_ADDR_SRHI   4'h5
`define DCT_ADDR_WRLO   4'h6
`define DCT_ADDR_WRHI   4'h7
`define DCT_ADDR_WCLO   4'h8
`define DCT_ADDR_WCHI   4'h9
`define DCT_ADDR_SCLO   4'hA
`define DCT_ADDR_SCHI   4'hB

// short and wide timer control fields
`define DCT_EN          7
`define DCT_ONE         6
`define DCT_TO          5
`define DCT_CAP         4
`define DCT_CIE         2
`define DCT_TIE         1

// shared control fields
`define DCT_TX          7
`define DCT_EDGF        5
`define DCT_EDGR        4
`define DCT_PPH         3
`define DCT_PPL         2
`define DCT_SINIT       1
`define DCT_WINIT       0

// reset values
`define DCT_RST_BYTE    8'h00
`define DCT_RST_WORD    16'h0000

`endif

// file: dct_down_counter.v
`default_nettype none

// loadable down counter; wraps from zero to all ones
module dct_down_counter #(
    parameter WIDTH = 8
) (
    // clock and reset
    input  wire             clk,
    input  wire             rst,
    // control
    input  wire             load,
    input  wire [WIDTH-1:0] loadVal,
    input  wire             run,
    // state
    output wire [WIDTH-1:0] count,
    output wire             terminal
);
    reg [WIDTH-1:0] cnt_q;
    reg             fresh_q;

    // zero reached by counting, not by a fresh load of zero
    assign terminal = run && (cnt_q == {WIDTH{1'b0}}) && !fresh_q;
    assign count    = cnt_q;

    // load wins over counting; zero steps on to all ones
    always @(posedge clk) begin
        if (rst) begin
            cnt_q   <= {WIDTH{1'b0}};
            fresh_q <= 1'b0;
        end else if (load) begin
            cnt_q   <= loadVal;
            fresh_q <= 1'b1;
        end else if (run) begin
            cnt_q   <= cnt_q - {{(WIDTH-1){1'b0}}, 1'b1};
            fresh_q <= 1'b0;
        end
    end
endmodule // dct_down_counter

`default_nettype wire

// file: dct_signal_source.sv
`default_nettype none
// measured-line source: square wave while running, held low when idle
module dct_signal_source (
    // clock
    input  wire logic       clk,
    // wave request
    input  wire logic       run,
    input  wire logic [8:0] hiLen,
    input  wire logic [8:0] loLen,
    // line toward the device
    output var  logic       measIn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] left_q = 9'h000;
    initial measIn = 1'b0;
    // each phase lasts its programmed number of clocks
    always @(posedge clk) begin
        if (!run) begin
            measIn <= 1'b0;
            left_q <= 9'h000;
        end else if (left_q <= 9'h001) begin
            measIn <= !measIn;
            left_q <= measIn ? loLen : hiLen;
        end else begin
            left_q <= left_q - 9'h001;
        end
    end
endmodule // dct_signal_source
`default_nettype wire

// file: dct_timer_pair.v
// What this block does
// - high-phase count goes to short high capture
// - low-phase count goes to short low capture
// - wide capture split into msb and lsb
// - capture reads return value; writes ignored
// - short enable sets level, loads matching reload
// - one-shot: stop, toggle, flag, optional interrupt
// - repeating: toggle, reload by new level
// - new reload values apply at next load
// - count zero wraps through all ones
// - wide single-pass ignores edges after first
// - single-pass short timeout captures wide count, no reload
// - single-pass rewritten zero-one rearms first edge
// - wide zero wraps, flags timeout, optional interrupt
// - either enable starts alternating operation
// - short end hands to wide, wide back
// - each timer interrupts at its terminal count
// - writing select field zero stops alternating
`include "dct_consts.vh"
`default_nettype none

module dct_timer_pair (
    // clock and reset
    input  wire       clk,
    input  wire       rst,
    // bank D register port
    input  wire [3:0] regAddr,
    input  wire       regWrEn,
    input  wire [7:0] regWrData,
    output reg  [7:0] regRdData_q,
    // link pins
    input  wire       measIn,
    output reg        shortOut_q,
    output reg        wideOut_q,
    // interrupt requests
    output reg        shortIrq_q,
    output reg        wideIrq_q
);
    // control and data registers
    reg  [7:0]  sCtl_q;
    reg  [7:0]  shCtl_q;
    reg  [7:0]  wCtl_q;
    reg  [7:0]  sRelLo_q;
    reg  [7:0]  sRelHi_q;
    reg  [7:0]  wRelLo_q;
    reg  [7:0]  wRelHi_q;
    reg  [7:0]  capSHi_q;
    reg  [7:0]  capSLo_q;
    reg  [15:0] capW_q;
    reg         armed_q;
    // input synchroniser and filtered level
    reg         sync1_q;
    reg         sync2_q;
    reg         sync3_q;
    reg         lvl_q;
    // next values
    reg  [7:0]  sCtl_d;
    reg  [7:0]  wCtl_d;
    reg  [7:0]  capSHi_d;
    reg  [7:0]  capSLo_d;
    reg  [15:0] capW_d;
    reg         armed_d;
    reg         sOut_d;
    reg         wOut_d;
    reg  [7:0]  rd_d;
    // counter controls
    reg         sLoad;
    reg  [7:0]  sLoadVal;
    reg         wLoad;
    reg  [15:0] wLoadVal;
    wire [7:0]  sCount;
    wire [15:0] wCount;
    wire        sTerm;
    wire        wTerm;

    // decoded strobes and mode terms
    wire wrSCtl  = regWrEn && (regAddr == `DCT_ADDR_SCTL);
    wire wrShCtl = regWrEn && (regAddr == `DCT_ADDR_SHCTL);
    wire wrWCtl  = regWrEn && (regAddr == `DCT_ADDR_WCTL);
    wire txMode  = shCtl_q[`DCT_TX];
    wire ppOn    = txMode && (shCtl_q[`DCT_PPH:`DCT_PPL] != 2'b00);
    wire sStart  = wrSCtl && regWrData[`DCT_EN] && !sCtl_q[`DCT_EN];
    wire wStart  = wrWCtl && regWrData[`DCT_EN] && !wCtl_q[`DCT_EN];
    wire sKick   = ppOn && wTerm;
    wire wKick   = ppOn && sTerm;
    wire wWide   = wrWCtl && regWrData[`DCT_ONE] && !wCtl_q[`DCT_ONE];

    // input edges count once the second and third stages agree
    wire lvlNew  = (sync2_q == sync3_q) ? sync3_q : lvl_q;
    wire inEdge  = lvlNew != lvl_q;
    wire inRise  = inEdge && lvlNew;
    wire inFall  = inEdge && !lvlNew;
    wire selEdge = (inRise && shCtl_q[`DCT_EDGR]) || (inFall && shCtl_q[`DCT_EDGF]);

    // elapsed ticks since the short counter was cleared
    wire [7:0] sElapsed = 8'h00 - sCount;

    dct_down_counter #(
        .WIDTH(8)
    ) uShort (
        .clk      (clk),
        .rst      (rst),
        .load     (sLoad),
        .loadVal  (sLoadVal),
        .run      (sCtl_q[`DCT_EN]),
        .count    (sCount),
        .terminal (sTerm)
    );

    dct_down_counter #(
        .WIDTH(16)
    ) uWide (
        .clk      (clk),
        .rst      (rst),
        .load     (wLoad),
        .loadVal  (wLoadVal),
        .run      (wCtl_q[`DCT_EN]),
        .count    (wCount),
        .terminal (wTerm)
    );

    // next-state logic: software writes first, hardware sets win after
    always @* begin
        sCtl_d   = sCtl_q;
        wCtl_d   = wCtl_q;
        capSHi_d = capSHi_q;
        capSLo_d = capSLo_q;
        capW_d   = capW_q;
        armed_d  = armed_q;
        sOut_d   = shortOut_q;
        wOut_d   = wideOut_q;
        sLoad    = 1'b0;
        sLoadVal = 8'h00;
        wLoad    = 1'b0;
        wLoadVal = {wRelHi_q, wRelLo_q};
        // status flags clear by writing one
        if (wrSCtl) begin
            sCtl_d = {regWrData[7:6], sCtl_q[5:4] & ~regWrData[5:4], regWrData[3:0]};
        end
        if (wrWCtl) begin
            wCtl_d = {regWrData[7:6], wCtl_q[5:4] & ~regWrData[5:4], regWrData[3:0]};
        end
        if (wWide || wStart) begin
            armed_d = 1'b1;
        end
        if (txMode) begin
            // short timer waveform
            if (sStart || sKick) begin
                sCtl_d[`DCT_EN] = 1'b1;
                sOut_d = shCtl_q[`DCT_SINIT];
                sLoad = 1'b1;
                sLoadVal = shCtl_q[`DCT_SINIT] ? sRelHi_q : sRelLo_q;
            end else if (sTerm) begin
                sOut_d = !shortOut_q;
                sCtl_d[`DCT_TO] = 1'b1;
                if (ppOn || sCtl_q[`DCT_ONE]) begin
                    sCtl_d[`DCT_EN] = 1'b0;
                end else begin
                    sLoad = 1'b1;
                    sLoadVal = shortOut_q ? sRelLo_q : sRelHi_q;
                end
            end
            // wide timer waveform
            if (wStart || wKick) begin
                wCtl_d[`DCT_EN] = 1'b1;
                wOut_d = shCtl_q[`DCT_WINIT];
                wLoad = 1'b1;
            end else if (wTerm) begin
                wOut_d = !wideOut_q;
                wCtl_d[`DCT_TO] = 1'b1;
                if (ppOn || wCtl_q[`DCT_ONE]) begin
                    wCtl_d[`DCT_EN] = 1'b0;
                end else begin
                    wLoad = 1'b1;
                end
            end
        end else begin
            // short timer measures each phase of the input
            if (sStart) begin
                sLoad = 1'b1;
            end else if (sCtl_q[`DCT_EN] && inEdge) begin
                if (lvl_q) begin
                    capSHi_d = sElapsed;
                end else begin
                    capSLo_d = sElapsed;
                end
                sCtl_d[`DCT_CAP] = 1'b1;
                sLoad = 1'b1;
            end else if (sTerm) begin
                sCtl_d[`DCT_TO] = 1'b1;
            end
            // wide timer captures on selected edges
            if (wStart) begin
                wLoad = 1'b1;
            end else if (wCtl_q[`DCT_EN]) begin
                if (wCtl_q[`DCT_ONE]) begin
                    if (selEdge && armed_q) begin
                        capW_d = wCount;
                        wLoad = 1'b1;
                        armed_d = 1'b0;
                        wCtl_d[`DCT_CAP] = 1'b1;
                    end else if (sTerm) begin
                        capW_d = wCount;
                        wCtl_d[`DCT_CAP] = 1'b1;
                    end
                end else if (selEdge) begin
                    capW_d = wCount;
                    wLoad = 1'b1;
                    wCtl_d[`DCT_CAP] = 1'b1;
                end
                if (wTerm) begin
                    wCtl_d[`DCT_TO] = 1'b1;
                end
            end
        end
    end

    // read data multiplexer, registered one cycle after the address
    always @* begin
        case (regAddr)
            `DCT_ADDR_SCTL:  rd_d = sCtl_q;
            `DCT_ADDR_SHCTL: rd_d = shCtl_q;
            `DCT_ADDR_WCTL:  rd_d = wCtl_q;
            `DCT_ADDR_SRLO:  rd_d = sRelLo_q;
            `DCT_ADDR_SRHI:  rd_d = sRelHi_q;
            `DCT_ADDR_WRLO:  rd_d = wRelLo_q;
            `DCT_ADDR_WRHI:  rd_d = wRelHi_q;
            `DCT_ADDR_WCLO:  rd_d = capW_q[7:0];
            `DCT_ADDR_WCHI:  rd_d = capW_q[15:8];
            `DCT_ADDR_SCLO:  rd_d = capSLo_q;
            `DCT_ADDR_SCHI:  rd_d = capSHi_q;
            default:         rd_d = 8'h00;
        endcase
    end

    // input synchroniser, three stages
    always @(posedge clk) begin
        if (rst) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
            lvl_q   <= 1'b0;
        end else begin
            sync1_q <= measIn;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            lvl_q   <= lvlNew;
        end
    end

    // register file; capture registers ignore writes
    always @(posedge clk) begin
        if (rst) begin
            sCtl_q   <= `DCT_RST_BYTE;
            shCtl_q  <= `DCT_RST_BYTE;
            wCtl_q   <= `DCT_RST_BYTE;
            sRelLo_q <= `DCT_RST_BYTE;
            sRelHi_q <= `DCT_RST_BYTE;
            wRelLo_q <= `DCT_RST_BYTE;
            wRelHi_q <= `DCT_RST_BYTE;
            capSHi_q <= `DCT_RST_BYTE;
            capSLo_q <= `DCT_RST_BYTE;
            capW_q   <= `DCT_RST_WORD;
            armed_q  <= 1'b0;
        end else begin
            sCtl_q   <= sCtl_d;
            wCtl_q   <= wCtl_d;
            capSHi_q <= capSHi_d;
            capSLo_q <= capSLo_d;
            capW_q   <= capW_d;
            armed_q  <= armed_d;
            if (wrShCtl) begin
                shCtl_q <= regWrData;
            end
            if (regWrEn && regAddr == `DCT_ADDR_SRLO) begin
                sRelLo_q <= regWrData;
            end
            if (regWrEn && regAddr == `DCT_ADDR_SRHI) begin
                sRelHi_q <= regWrData;
            end
            if (regWrEn && regAddr == `DCT_ADDR_WRLO) begin
                wRelLo_q <= regWrData;
            end
            if (regWrEn && regAddr == `DCT_ADDR_WRHI) begin
                wRelHi_q <= regWrData;
            end
        end
    end

    // outputs, read data and interrupt levels
    always @(posedge clk) begin
        if (rst) begin
            shortOut_q  <= 1'b0;
            wideOut_q   <= 1'b0;
            regRdData_q <= `DCT_RST_BYTE;
            shortIrq_q  <= 1'b0;
            wideIrq_q   <= 1'b0;
        end else begin
            shortOut_q  <= sOut_d;
            wideOut_q   <= wOut_d;
            regRdData_q <= rd_d;
            shortIrq_q  <= sCtl_q[`DCT_TO] && sCtl_q[`DCT_TIE];
            wideIrq_q   <= (wCtl_q[`DCT_TO] && wCtl_q[`DCT_TIE])
                        || (wCtl_q[`DCT_CAP] && wCtl_q[`DCT_CIE]);
        end
    end
endmodule // dct_timer_pair

`default_nettype wire

// file: dct_timer_pair_tb_top.sv
`default_nettype none
module dct_timer_pair_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 1'b0, rst = 1'b1, regWrEn = 1'b0, run = 1'b0, lastOut = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWrData = 8'h00, regRdData_q;
    logic       measIn, shortOut_q, wideOut_q, shortIrq_q, wideIrq_q;
    logic [8:0] hiLen = 9'h00A, loLen = 9'h00A;
    int         miscompares = 0, nChecks = 0, runLen = 0, n, k;
    int         phaseLen[$];
    logic [7:0] d, h1, h2, l1, l2;
    // 125 MHz clock
    always #4 clk = ~clk;
    dct_timer_pair u_dct_timer_pair (.clk(clk), .rst(rst), .regAddr(regAddr),
        .regWrEn(regWrEn), .regWrData(regWrData), .regRdData_q(regRdData_q),
        .measIn(measIn), .shortOut_q(shortOut_q), .wideOut_q(wideOut_q),
        .shortIrq_q(shortIrq_q), .wideIrq_q(wideIrq_q));
    dct_signal_source u_dct_signal_source (.clk(clk), .run(run), .hiLen(hiLen),
        .loLen(loLen), .measIn(measIn));
    // record every short output phase length
    always @(negedge clk) begin
        runLen++;
        if (shortOut_q !== lastOut) begin
            phaseLen.push_back(runLen);
            runLen = 0;
        end
        lastOut = shortOut_q;
    end
    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        nChecks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chkRange(input string what, input logic [15:0] lo, hi, got);
        nChecks++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            miscompares++;
            $display("unexpected %s: expected %h..%h seen %h", what, lo, hi, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(negedge clk);
        regAddr = a;
        regWrData = v;
        regWrEn = 1'b1;
        @(negedge clk);
        regWrEn = 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(negedge clk);
        regAddr = a;
        @(negedge clk);
        v = regRdData_q;
    endtask
    task automatic waitChg(input bit useWide);
        logic v;
        int   c;
        v = useWide ? wideOut_q : shortOut_q;
        c = 0;
        do begin
            @(negedge clk);
            c++;
        end while ((useWide ? wideOut_q : shortOut_q) === v && c < 600);
        check8("output change", 8'h01, {7'h00, c < 600});
    endtask
    task automatic testResetValues();
        for (int a = 0; a < 16; a++) begin
            rd(a[3:0], d);
            check8("register after reset", 8'h00, d);
        end
    endtask
    task automatic testOneShot();
        wr(4'h1, 8'h82);
        wr(4'h5, 8'h05);
        wr(4'h4, 8'h09);
        wr(4'h0, 8'hC2);
        @(negedge clk);
        check8("short initial level", 8'h01, {7'h00, shortOut_q});
        waitChg(1'b0);
        repeat (40) @(negedge clk);
        check8("short irq at timeout", 8'h01, {7'h00, shortIrq_q});
        rd(4'h0, d);
        check8("short control after timeout", 8'h62, d);
        wr(4'h0, 8'h62);
        @(negedge clk);
        check8("short irq after clear", 8'h00, {7'h00, shortIrq_q});
    endtask
    task automatic testRepeat();
        wr(4'h1, 8'h80);
        wr(4'h4, 8'h03);
        wr(4'h5, 8'h07);
        phaseLen.delete();
        wr(4'h0, 8'h80);
        repeat (30) @(negedge clk);
        wr(4'h5, 8'h00);
        repeat (400) @(negedge clk);
        wr(4'h0, 8'h00);
        k = 0;
        foreach (phaseLen[i]) if (k == 0 && phaseLen[i] > 100) k = i;
        check8("high minus low phase", 8'h04, 8'(phaseLen[1] - phaseLen[2]));
        // reload N lasts N+1 clocks; zero counts 256 steps plus the terminal clock
        check8("zero reload phase", 8'hFD, 8'(phaseLen[k] - phaseLen[2]));
        check8("high phase before reload", 8'(phaseLen[1]), 8'(phaseLen[k - 2]));
    endtask
    task automatic testCaptureShort();
        wr(4'h1, 8'h30);
        wr(4'h0, 8'h80);
        {hiLen, loLen, run} = {9'h014, 9'h00C, 1'b1};
        repeat (200) @(negedge clk);
        rd(4'hB, h1);
        rd(4'hA, l1);
        {hiLen, loLen} = {9'h01E, 9'h028};
        repeat (300) @(negedge clk);
        rd(4'hB, h2);
        rd(4'hA, l2);
        check8("high phase capture step", 8'h0A, h2 - h1);
        check8("low phase capture step", 8'h1C, l2 - l1);
        run = 1'b0;
        repeat (20) @(negedge clk);
        rd(4'hB, h1);
        wr(4'hB, 8'h55);
        rd(4'hB, h2);
        check8("capture after write", h1, h2);
    endtask
    task automatic testWidePass();
        wr(4'h0, 8'h20);
        wr(4'h6, 8'h34);
        wr(4'h7, 8'h12);
        wr(4'h1, 8'h10);
        wr(4'h0, 8'h80);
        wr(4'h2, 8'hC4);
        {hiLen, loLen, run} = {9'h00A, 9'h00A, 1'b1};
        repeat (200) @(negedge clk);
        run = 1'b0;
        d = 8'h00;
        n = 0;
        while (d[5] !== 1'b1 && n < 200) begin
            rd(4'h0, d);
            n++;
        end
        rd(4'h9, h1);
        rd(4'h8, l1);
        chkRange("wide elapsed count", 16'h01A0, 16'h01F4, 16'h1234 - {h1, l1});
        check8("wide capture irq", 8'h01, {7'h00, wideIrq_q});
    endtask
    task automatic testAlternate();
        wr(4'h2, 8'h30);
        wr(4'h0, 8'h30);
        wr(4'h5, 8'h04);
        wr(4'h6, 8'h08);
        wr(4'h7, 8'h00);
        wr(4'h1, 8'h87);
        wr(4'h2, 8'h40);
        wr(4'h0, 8'h40);
        wr(4'h0, 8'hC2);
        waitChg(1'b0);
        repeat (3) @(negedge clk);
        // wide initial level is one, so the handoff must visibly raise it
        check8("wide level at handoff", 8'h01, {7'h00, wideOut_q});
        check8("short irq at end", 8'h01, {7'h00, shortIrq_q});
        waitChg(1'b1);
        // short restarts at its initial level on the same edge as the wide end
        check8("short level on return", 8'h01, {7'h00, shortOut_q});
        waitChg(1'b0);
        wr(4'h1, 8'h82);
        repeat (60) @(negedge clk);
        n = phaseLen.size();
        repeat (100) @(negedge clk);
        check8("short phases after stop", 8'h00, 8'(phaseLen.size() - n));
    endtask
    task automatic finalReport();
        $display("checks %0d miscompares %0d", nChecks, miscompares);
        if (miscompares == 0 && nChecks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // main sequence after a 16-cycle reset
    initial begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        testResetValues();
        testOneShot();
        testRepeat();
        testCaptureShort();
        testWidePass();
        testAlternate();
        finalReport();
    end
    // watchdog well beyond the expected run
    initial begin
        #(8 * 20000);
        miscompares++;
        finalReport();
    end
endmodule // dct_timer_pair_tb_top
bind dct_timer_pair dct_checker u_dct_checker (.clk(clk), .rst(rst), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdData_q(regRdData_q), .measIn(measIn),
    .shortOut_q(shortOut_q), .wideOut_q(wideOut_q), .shortIrq_q(shortIrq_q),
    .wideIrq_q(wideIrq_q));
`default_nettype wire
